/* rtl/wkt_timer.sv */
// wake-up timer with card-probe and oscillator calibrate triggers.
// assumes an apb master on ref_clk and a one-cycle slowTick pulse per
// slow oscillator period, synchronous to ref_clk.
//
// Functional notes
// - control bit 7 reads countdown active
// - writes change run state only with strobe bit 6
// - auto calibrate pulses at each underflow
// - auto card probe launched on underflow
// - card found raises interrupt, stays active
// - no card returns to power-down if enabled
// - card probe restarts countdown without gap
// - fourth general timer times field-on window
// - auto reload or card probe continues, else stop at zero
// - every underflow sets timer interrupt flag
// - auto wake requests wake on underflow
// - tick select divides by 1, 8, 16, 32
// - start loads counter from reload bytes
// - reload writes wait for next start or reload
// - live count readable at high, low bytes
`include "wkt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wkt_timer (
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`WKT_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   input  wire logic                    slowTick,
   input  wire logic                    probeDone,
   input  wire logic                    probeCardFound,
   output logic                         probeFieldTimerUse,
   output logic                         stayActive,
   output wkt_pkg::wkt_req_t            requests,
   output logic                         irq
);

   logic                   rstMeta_q;
   logic                   rstN_q;
   wkt_pkg::wkt_ctrl_t     ctrl_q;
   logic                   running_q;
   logic [`WKT_CNT_W-1:0]  reload_q;
   logic [`WKT_CNT_W-1:0]  count_q;
   logic [`WKT_PRE_W-1:0]  pre_q;
   logic [`WKT_IRQ_W-1:0]  stat_q;
   logic [`WKT_IRQ_W-1:0]  mask_q;
   logic                   ready_q;
   logic [31:0]            rdata_q;
   logic                   stay_q;
   wkt_pkg::wkt_req_t      req_q;

   // reset release through two flops, assert stays asynchronous
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end

   // apb decode; one wait state so read data comes from a flop
   wire accessPhase = psel & penable;
   wire xferDone    = accessPhase & ready_q;
   wire wrDone      = xferDone & pwrite;
   wire rdDone      = xferDone & ~pwrite;
   wire [9:0] idx   = paddr[`WKT_ADDR_W-1:2];
   wire selCtrl     = idx == `WKT_IDX_CTRL;
   wire selRldHi    = idx == `WKT_IDX_RLD_HI;
   wire selRldLo    = idx == `WKT_IDX_RLD_LO;
   wire selCntHi    = idx == `WKT_IDX_CNT_HI;
   wire selCntLo    = idx == `WKT_IDX_CNT_LO;
   wire selStat     = idx == `WKT_IDX_IRQ_STAT;
   wire selMask     = idx == `WKT_IDX_IRQ_MASK;
   wire lowBitsOk   = paddr[1:0] == 2'h0;
   wire mapped      = lowBitsOk & (selCtrl | selRldHi | selRldLo
                      | selCntHi | selCntLo | selStat | selMask);
   wire ctrlWr      = wrDone & mapped & selCtrl;
   // of all writes, only one carrying the strobe moves the run state
   wire runChange   = ctrlWr & pwdata[`WKT_BIT_STRB];
   wire startEv     = runChange & pwdata[`WKT_BIT_RUNNING];
   wire stopEv      = runChange & ~pwdata[`WKT_BIT_RUNNING];

   // read mux; counter bytes are live, strobe bit reads zero
   // refused addresses read zero even when the index alone decodes
   logic [7:0] rdMux;
   assign rdMux =
      ~mapped  ? 8'h00 :
      selCtrl  ? {running_q, 1'b0, ctrl_q} :
      selRldHi ? reload_q[15:8] :
      selRldLo ? reload_q[7:0] :
      selCntHi ? count_q[15:8] :
      selCntLo ? count_q[7:0] :
      selStat  ? {6'h00, stat_q} :
      selMask  ? {6'h00, mask_q} : 8'h00;

   // tick prescaler: compare limit picked by the select field
   wire [`WKT_PRE_W-1:0] preLimit =
      (ctrl_q.tickSourceSelect == 2'h0) ? `WKT_DIV_1 :
      (ctrl_q.tickSourceSelect == 2'h1) ? `WKT_DIV_8 :
      (ctrl_q.tickSourceSelect == 2'h2) ? `WKT_DIV_16 :
      `WKT_DIV_32;
   wire preWrap  = pre_q == preLimit;
   wire tick     = running_q & slowTick & preWrap;
   // count of one (or a zero reload) reaches zero on this tick
   wire atZero   = tick & (count_q <= 16'h0001);
   // card probe forces a gapless restart even without auto reload
   wire keepOn   = ctrl_q.autoReloadOnZero | ctrl_q.autoCardProbe;
   wire cardEv   = probeDone & probeCardFound;
   wire emptyEv  = probeDone & ~probeCardFound;

   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ready_q <= accessPhase & ~ready_q;
         if (accessPhase & ~ready_q & ~pwrite)
            rdata_q <= {24'h00_0000, rdMux};
      end
   end

   assign pready  = ready_q;
   assign pslverr = ready_q & ~mapped;
   assign prdata  = rdata_q;

   // software fields; reload bytes only latch, count is untouched
   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         ctrl_q   <= `WKT_CTRL_RST;
         reload_q <= `WKT_RLD_RST;
         mask_q   <= `WKT_MASK_RST;
      end
      else
      begin
         if (ctrlWr)
            ctrl_q <= pwdata[`WKT_BIT_TRIM:`WKT_SEL_LO];
         if (wrDone & mapped & selRldHi)
            reload_q[15:8] <= pwdata[7:0];
         if (wrDone & mapped & selRldLo)
            reload_q[7:0] <= pwdata[7:0];
         if (wrDone & mapped & selMask)
            mask_q <= pwdata[`WKT_IRQ_W-1:0];
      end
   end

   // prescaler restarts with every start so the first tick is whole
   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
         pre_q <= 5'h00;
      else if (startEv | ~running_q)
         pre_q <= 5'h00;
      else if (slowTick)
         pre_q <= preWrap ? 5'h00 : pre_q + 5'h01;
   end

   // run state and counter
   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         running_q <= 1'b0;
         count_q   <= 16'h0000;
      end
      else if (startEv)
      begin
         running_q <= 1'b1;
         count_q   <= reload_q;
      end
      else if (stopEv)
         running_q <= 1'b0;
      else if (atZero)
      begin
         running_q <= keepOn;
         count_q   <= keepOn ? reload_q : 16'h0000;
      end
      else if (tick)
         count_q <= count_q - 16'h0001;
   end

   // sticky flags: a read clears them, a fresh event wins over that
   wire [`WKT_IRQ_W-1:0] statSet = {cardEv, atZero};
   wire statClr = rdDone & mapped & selStat;
   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
         stat_q <= 2'h0;
      else
         stat_q <= (statClr ? 2'h0 : stat_q) | statSet;
   end

   assign irq = |(stat_q & mask_q);

   // requests to calibrator, probe sequencer and power controller
   always_ff @(posedge ref_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         req_q  <= 4'h0;
         stay_q <= 1'b0;
      end
      else
      begin
         req_q.calibrateStart   <= atZero & ctrl_q.autoOscCalibrate;
         req_q.probeStart       <= atZero & ctrl_q.autoCardProbe;
         req_q.wakeRequest      <= atZero & ctrl_q.autoWakeOnZero;
         req_q.powerDownRequest <= emptyEv & ctrl_q.autoWakeOnZero;
         // a found card holds the chip up until the next empty probe
         if (cardEv)
            stay_q <= 1'b1;
         else if (emptyEv)
            stay_q <= 1'b0;
      end
   end

   assign requests           = req_q;
   assign stayActive         = stay_q;
   // field-on window is timed by the fourth general timer
   assign probeFieldTimerUse = ctrl_q.autoCardProbe;

   // checks beside the logic
   property p_run_hold;
      @(posedge ref_clk) disable iff (!rstN_q)
      (ctrlWr & ~pwdata[`WKT_BIT_STRB] & ~atZero) |=> running_q == $past(running_q);
   endproperty
   a_run_hold: assert property (p_run_hold)
      else $error("run state moved without strobe");

   property p_start_load;
      @(posedge ref_clk) disable iff (!rstN_q)
      startEv |=> running_q && count_q == $past(reload_q);
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("start did not load reload value");

   property p_stop_at_zero;
      @(posedge ref_clk) disable iff (!rstN_q)
      (atZero & ~keepOn & ~runChange) |=> ~running_q && count_q == 16'h0000;
   endproperty
   a_stop_at_zero: assert property (p_stop_at_zero)
      else $error("counter did not stop at zero");

   property p_reload_on_zero;
      @(posedge ref_clk) disable iff (!rstN_q)
      (atZero & keepOn & ~runChange) |=> running_q && count_q == $past(reload_q);
   endproperty
   a_reload_on_zero: assert property (p_reload_on_zero)
      else $error("no gapless restart after zero");

   property p_flag_set;
      @(posedge ref_clk) disable iff (!rstN_q)
      atZero |=> stat_q[`WKT_IRQ_ZERO];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("underflow flag not set");

   property p_decrement;
      @(posedge ref_clk) disable iff (!rstN_q)
      (tick & ~atZero & ~runChange) |=> count_q == $past(count_q) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("counter did not step down");

   property p_reload_no_disturb;
      @(posedge ref_clk) disable iff (!rstN_q)
      (wrDone & (selRldHi | selRldLo) & ~tick & ~runChange)
      |=> count_q == $past(count_q);
   endproperty
   a_reload_no_disturb: assert property (p_reload_no_disturb)
      else $error("reload write changed the count");

   property p_calibrate;
      @(posedge ref_clk) disable iff (!rstN_q)
      (atZero & ctrl_q.autoOscCalibrate) |=> requests.calibrateStart;
   endproperty
   a_calibrate: assert property (p_calibrate)
      else $error("calibrate not triggered");

   property p_probe;
      @(posedge ref_clk) disable iff (!rstN_q)
      requests.probeStart |-> $past(atZero) && $past(ctrl_q.autoCardProbe);
   endproperty
   a_probe: assert property (p_probe)
      else $error("probe start without underflow");

   property p_wake;
      @(posedge ref_clk) disable iff (!rstN_q)
      requests.wakeRequest |-> $past(atZero) && $past(ctrl_q.autoWakeOnZero);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake request without cause");

   property p_card_irq;
      @(posedge ref_clk) disable iff (!rstN_q)
      (cardEv & mask_q[`WKT_IRQ_CARD] & ~(wrDone & mapped & selMask))
      |=> irq && stayActive;
   endproperty
   a_card_irq: assert property (p_card_irq)
      else $error("card found but no interrupt");

   property p_power_down;
      @(posedge ref_clk) disable iff (!rstN_q)
      (emptyEv & ctrl_q.autoWakeOnZero) |=> requests.powerDownRequest && !stayActive;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("empty probe did not request power-down");

   property p_tick_div;
      @(posedge ref_clk) disable iff (!rstN_q)
      (tick & ctrl_q.tickSourceSelect == 2'h1) |-> pre_q == `WKT_DIV_8;
   endproperty
   a_tick_div: assert property (p_tick_div)
      else $error("divide-by-8 tick at wrong count");

   property p_running_read;
      @(posedge ref_clk) disable iff (!rstN_q)
      (accessPhase & ~ready_q & ~pwrite & mapped & selCtrl)
      |=> prdata[`WKT_BIT_RUNNING] == $past(running_q);
   endproperty
   a_running_read: assert property (p_running_read)
      else $error("running bit misreported");

   property p_count_read;
      @(posedge ref_clk) disable iff (!rstN_q)
      (accessPhase & ~ready_q & ~pwrite & mapped & selCntLo)
      |=> prdata[7:0] == $past(count_q[7:0]);
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("count low byte misreported");

   property p_field_timer;
      @(posedge ref_clk) disable iff (!rstN_q)
      probeFieldTimerUse == ctrl_q.autoCardProbe;
   endproperty
   a_field_timer: assert property (p_field_timer)
      else $error("field timer routing wrong");

endmodule : wkt_timer

`default_nettype wire

/* shared/wkt_cfg.svh */
// constants of the wake-up timer: register indices, field positions,
// reset values and divider figures. definitions only.
`ifndef WKT_CFG_SVH
`define WKT_CFG_SVH

`define WKT_ADDR_W        12
`define WKT_IDX_CTRL      10'h023
`define WKT_IDX_RLD_HI    10'h024
`define WKT_IDX_RLD_LO    10'h025
`define WKT_IDX_CNT_HI    10'h026
`define WKT_IDX_CNT_LO    10'h027
`define WKT_IDX_IRQ_STAT  10'h030
`define WKT_IDX_IRQ_MASK  10'h031

`define WKT_BIT_RUNNING   7
`define WKT_BIT_STRB      6
`define WKT_BIT_TRIM      5
`define WKT_BIT_PROBE     4
`define WKT_BIT_RELOAD    3
`define WKT_BIT_WAKE      2
`define WKT_SEL_HI        1
`define WKT_SEL_LO        0

`define WKT_IRQ_ZERO      0
`define WKT_IRQ_CARD      1
`define WKT_IRQ_W         2

`define WKT_CNT_W         16
`define WKT_PRE_W         5
`define WKT_DIV_1         5'h00
`define WKT_DIV_8         5'h07
`define WKT_DIV_16        5'h0f
`define WKT_DIV_32        5'h1f

`define WKT_CTRL_RST      6'h00
`define WKT_RLD_RST       16'h0000
`define WKT_MASK_RST      2'h0

`endif

/* shared/wkt_pkg.sv */
// types shared by the wake-up timer and its bench.
// assumes wkt_cfg.svh holds the numbers.
`default_nettype none

package wkt_pkg;

   // software-held control fields
   typedef struct packed {
      logic       autoOscCalibrate;
      logic       autoCardProbe;
      logic       autoReloadOnZero;
      logic       autoWakeOnZero;
      logic [1:0] tickSourceSelect;
   } wkt_ctrl_t;

   // one-cycle requests to neighbouring blocks
   typedef struct packed {
      logic calibrateStart;
      logic probeStart;
      logic wakeRequest;
      logic powerDownRequest;
   } wkt_req_t;

endpackage : wkt_pkg

`default_nettype wire

/* dv/wkt_timer_test.sv */
// self-checking bench of the wake-up timer: apb register access, countdown,
// prescaler, card probe hand-off and interrupt. assumes wkt_cfg.svh on the path.
`include "wkt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wkt_timer_test;
   logic                 ref_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0;
   logic                 pready;
   logic [31:0]          prdata;
   logic                 pslverr;
   logic                 slowTick = 1'b0;
   logic                 probeDone = 1'b0;
   logic                 probeCardFound = 1'b0;
   logic                 probeFieldTimerUse;
   logic                 stayActive;
   wkt_pkg::wkt_req_t    requests;
   logic                 irq;
   int                   err_total = 0;
   int                   samples_checked = 0;
   int                   calN = 0, prbN = 0, wakeN = 0, pdN = 0;
   int                   rld;
   int                   seed = 32'h8608;
   logic [31:0]          rd;
   logic                 er;
   logic [7:0]           rv;
   int                   divs [4] = '{1, 8, 16, 32};

   // 25 ns period
   always #12.5 ref_clk = ~ref_clk;

   wkt_timer wkt_timer_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .slowTick(slowTick),
      .probeDone(probeDone), .probeCardFound(probeCardFound),
      .probeFieldTimerUse(probeFieldTimerUse), .stayActive(stayActive),
      .requests(requests), .irq(irq));

   // pulses are one cycle wide, so counting per edge gives the event count
   always @(posedge ref_clk)
   begin
      if (requests.calibrateStart === 1'b1) calN++;
      if (requests.probeStart === 1'b1) prbN++;
      if (requests.wakeRequest === 1'b1) wakeN++;
      if (requests.powerDownRequest === 1'b1) pdN++;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one apb transfer; waits on pready, bounded
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h0, 32'h1);
   endtask : apb

   function automatic logic [11:0] ba(input logic [9:0] idx);
      return {idx, 2'b00};
   endfunction : ba

   task automatic wr8(input logic [9:0] idx, input logic [7:0] v);
      apb(1'b1, ba(idx), {24'h0, v});
   endtask : wr8

   task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] v);
      apb(1'b0, ba(idx), 32'h0);
      chk(what, rd, {24'h0, v});
   endtask : rdchk

   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         slowTick <= 1'b1;
         @(posedge ref_clk);
         slowTick <= 1'b0;
      end
   endtask : tick

   task automatic probe(input logic found);
      @(posedge ref_clk);
      probeDone <= 1'b1;
      probeCardFound <= found;
      @(posedge ref_clk);
      probeDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : probe

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // watchdog, far beyond the several hundred cycles the tests need
   initial
   begin
      #(25 * 20000);
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // reset values and refused addresses
      rdchk("ctrl", `WKT_IDX_CTRL, 8'h00);
      rdchk("rldHi", `WKT_IDX_RLD_HI, 8'h00);
      rdchk("cntLo", `WKT_IDX_CNT_LO, 8'h00);
      rdchk("mask", `WKT_IDX_IRQ_MASK, 8'h00);
      apb(1'b0, ba(10'h3ff), 32'h0);
      chk("unmappedErr", {31'h0, er}, 32'h1);
      chk("unmappedData", rd, 32'h0);
      apb(1'b1, 12'h08d, 32'h0);
      chk("misalignErr", {31'h0, er}, 32'h1);
      $display("test reset done");
      // one-shot with calibrate and wake
      rld = 3;
      wr8(`WKT_IDX_RLD_HI, 8'h00);
      wr8(`WKT_IDX_RLD_LO, rld[7:0]);
      wr8(`WKT_IDX_CTRL, 8'he4);
      rdchk("ctrlRun", `WKT_IDX_CTRL, 8'ha4);
      tick(2);
      rdchk("cntLo", `WKT_IDX_CNT_LO, 8'(rld - 2));
      tick(1);
      rdchk("cntZero", `WKT_IDX_CNT_LO, 8'h00);
      rdchk("ctrlStop", `WKT_IDX_CTRL, 8'h24);
      chk("calN", calN, 1);
      chk("wakeN", wakeN, 1);
      rdchk("stat", `WKT_IDX_IRQ_STAT, 8'h01);
      rdchk("statClr", `WKT_IDX_IRQ_STAT, 8'h00);
      $display("test oneshot done");
      // writes move the running state only with the strobe bit
      wr8(`WKT_IDX_CTRL, 8'h80);
      rdchk("noStrbStart", `WKT_IDX_CTRL, 8'h00);
      wr8(`WKT_IDX_CTRL, 8'hc8);
      wr8(`WKT_IDX_CTRL, 8'h08);
      rdchk("noStrbKeep", `WKT_IDX_CTRL, 8'h88);
      wr8(`WKT_IDX_CTRL, 8'h48);
      rdchk("strbStop", `WKT_IDX_CTRL, 8'h08);
      $display("test strobe done");
      // each tick source, and reload writes during a countdown
      for (int s = 0; s < 4; s++)
      begin
         rld = 16'h0100;
         wr8(`WKT_IDX_RLD_HI, 8'h01);
         wr8(`WKT_IDX_RLD_LO, 8'h00);
         wr8(`WKT_IDX_CTRL, 8'hc8 | 8'(s));
         tick(divs[s] - 1);
         rdchk("preHold", `WKT_IDX_CNT_LO, 8'h00);
         tick(1);
         rld = rld - 1;
         wr8(`WKT_IDX_RLD_LO, 8'h55);
         rdchk("preHi", `WKT_IDX_CNT_HI, 8'(rld >> 8));
         rdchk("preLo", `WKT_IDX_CNT_LO, 8'(rld));
         rdchk("rldLo", `WKT_IDX_RLD_LO, 8'h55);
         wr8(`WKT_IDX_CTRL, 8'h48 | 8'(s));
      end
      $display("test prescale done");
      // auto reload with masked and unmasked zero interrupt
      wr8(`WKT_IDX_RLD_HI, 8'h00);
      wr8(`WKT_IDX_RLD_LO, 8'h02);
      wr8(`WKT_IDX_IRQ_MASK, 8'h01);
      wr8(`WKT_IDX_CTRL, 8'hc8);
      tick(2);
      rdchk("autoReload", `WKT_IDX_CNT_LO, 8'h02);
      rdchk("stillRun", `WKT_IDX_CTRL, 8'h88);
      chk("irqSet", {31'h0, irq}, 32'h1);
      rdchk("statRd", `WKT_IDX_IRQ_STAT, 8'h01);
      repeat (2) @(posedge ref_clk);
      chk("irqClr", {31'h0, irq}, 32'h0);
      wr8(`WKT_IDX_IRQ_MASK, 8'h00);
      tick(2);
      chk("irqMasked", {31'h0, irq}, 32'h0);
      rdchk("statMasked", `WKT_IDX_IRQ_STAT, 8'h01);
      wr8(`WKT_IDX_CTRL, 8'h40);
      $display("test reload done");
      // card probe: launched on underflow, counts on, outcome handling
      wr8(`WKT_IDX_RLD_LO, 8'h01);
      wr8(`WKT_IDX_CTRL, 8'hd4);
      // the control write lands at the edge the task returns on
      @(posedge ref_clk);
      chk("fieldTimer", {31'h0, probeFieldTimerUse}, 32'h1);
      tick(1);
      // the probe pulse follows the underflow edge by one cycle
      repeat (2) @(posedge ref_clk);
      chk("prbN", prbN, 1);
      rdchk("probeRun", `WKT_IDX_CTRL, 8'h94);
      rdchk("probeCnt", `WKT_IDX_CNT_LO, 8'h01);
      wr8(`WKT_IDX_IRQ_MASK, 8'h02);
      probe(1'b1);
      chk("stayAct", {31'h0, stayActive}, 32'h1);
      chk("irqCard", {31'h0, irq}, 32'h1);
      rdchk("statCard", `WKT_IDX_IRQ_STAT, 8'h03);
      probe(1'b0);
      chk("pdN", pdN, 1);
      chk("stayOff", {31'h0, stayActive}, 32'h0);
      wr8(`WKT_IDX_CTRL, 8'h40);
      $display("test probe done");
      // random reload high bytes read back
      repeat (4)
      begin
         rv = 8'($random(seed));
         wr8(`WKT_IDX_RLD_HI, rv);
         rdchk("rndHi", `WKT_IDX_RLD_HI, rv);
      end
      $display("test random done");
      tally_and_finish();
   end
endmodule : wkt_timer_test

`default_nettype wire
